//--- verilog/imd_cfg.svh
// opcode, field, register and timing macros for the instruction decoder
`ifndef IMD_CFG_SVH
`define IMD_CFG_SVH
`define IMD_OPC_HI      23
`define IMD_OPC_LO      16
`define IMD_OP_NOP      8'h00
`define IMD_OP_ICALL    8'h01
`define IMD_OP_CALL     8'h02
`define IMD_OP_IGOTO    8'h03
`define IMD_OP_GOTO     8'h04
`define IMD_OP_RETURN   8'h06
`define IMD_OP_RETI     8'h07
`define IMD_OP_DO       8'h08
`define IMD_OP_BRA      8'h37
`define IMD_OP_CBR_GRP  4'h3
`define IMD_OP_SKIP_LO  8'hA4
`define IMD_OP_SKIP_HI  8'hA7
`define IMD_OP_TBLRD    8'hBA
`define IMD_OP_TBLWR    8'hBB
`define IMD_OP_MOVD     8'hBE
`define IMD_OP_MAC_GRP  4'hC
`define IMD_OP_SQR      8'hF0
`define IMD_CYC_BRANCH  2'h2
`define IMD_CYC_TABLE   2'h2
`define IMD_CYC_RETURN  2'h3
`define IMD_CYC_DMOVE   2'h2
`define IMD_CYC_TAKEN   2'h2
`define IMD_F_ACC       15
`define IMD_F_MM_HI     14
`define IMD_F_MM_LO     12
`define IMD_F_XPF_HI    11
`define IMD_F_XPF_LO    8
`define IMD_F_YPF_HI    7
`define IMD_F_YPF_LO    4
`define IMD_F_XD_HI     3
`define IMD_F_XD_LO     2
`define IMD_F_AWB_HI    1
`define IMD_F_AWB_LO    0
`define IMD_W0          4'h0
`define IMD_W4          4'h4
`define IMD_W8          4'h8
`define IMD_W10         4'hA
`define IMD_W12         4'hC
`define IMD_W13         4'hD
`define IMD_ADDR_STATUS 5'h00
`define IMD_ADDR_CTRL   5'h04
`define IMD_ADDR_COUNT  5'h08
`define IMD_ADDR_FAULT  5'h0C
`define IMD_RST_FLAGS   9'h000
`define IMD_RST_ENABLE  1'h1
`endif

//--- verilog/imd_pkg.sv
// types shared by the instruction decoder files
package imd_pkg;
    typedef enum logic [3:0] {
        CL_PLAIN, CL_NOP, CL_DWORD, CL_BRA, CL_CBRA, CL_IND,
        CL_TABLE, CL_RET, CL_SKIP, CL_DMOVE, CL_MAC, CL_SQR
    } imd_class_e;
    typedef enum logic [2:0] {
        ST_FIRST, ST_SECOND, ST_STALL, ST_SKIP1, ST_SKIP2
    } imd_state_e;
    typedef struct packed {
        logic sb; logic sa; logic ob; logic oa;
        logic z; logic ov; logic n; logic dc; logic c;
    } imd_flags_s;
    typedef struct packed {
        logic en; logic [3:0] rsel; logic [3:0] step; logic idx;
    } imd_pf_s;
    typedef struct packed {
        logic        acc_b;
        logic        awb_en;
        logic        awb_inc;
        logic [3:0]  awb_reg;
        logic        mul_ok;
        logic [3:0]  mul_m;
        logic [3:0]  mul_n;
        imd_pf_s     xpf;
        imd_pf_s     ypf;
        logic [3:0]  x_dest;
        logic [3:0]  bit_pos;
        logic [3:0]  default_work_register;
        logic [22:0] prog_lit;
        logic        lit_ok;
    } imd_fields_s;
    typedef struct packed {
        logic [23:0] word1;
        logic [23:0] word2;
        imd_class_e  cls;
        imd_fields_s f;
    } imd_exec_s;
    typedef struct packed {
        imd_state_e st;
        logic [1:0] cnt;
        logic [23:0] w1;
        imd_exec_s  ex;
        logic       ex_valid;
        logic       ex_nop;
        logic       orphan;
        imd_flags_s flags;
        logic       enable;
        logic [2:0] fault;
        logic [15:0] icount;
        logic       ack;
        logic [31:0] rdata;
    } imd_state_s;
endpackage

//--- verilog/imd_fields.sv
// operand field decoder for DSP, bit and program address forms
`timescale 1ns/100ps
`default_nettype none
`include "imd_cfg.svh"
module imd_fields
    import imd_pkg::*;
(
    input  wire logic [23:0] word1,
    input  wire logic [23:0] word2,
    input  wire imd_class_e  cls,
    output imd_fields_s      fields
);
    // prefetch code: 0 none, 1..7 low reg, 8..14 high reg, 15 high+W12
    function automatic imd_pf_s pf_dec(input logic [3:0] c,
                                       input logic [3:0] base);
        imd_pf_s    p;
        logic [2:0] k;
        p = '0;
        k = c[3] ? 3'(4'(c - 4'h7)) : c[2:0];
        p.en = (c != 4'h0);
        p.rsel = c[3] ? 4'(base + 4'h1) : base;
        p.idx = (c == 4'hF);
        case (k)
            3'h2: p.step = 4'h2;
            3'h3: p.step = 4'h4;
            3'h4: p.step = 4'h6;
            3'h5: p.step = 4'hE;
            3'h6: p.step = 4'hC;
            3'h7: p.step = 4'hA;
            default: p.step = 4'h0;
        endcase
        return p;
    endfunction

    logic [2:0] mm;
    assign mm = word1[`IMD_F_MM_HI:`IMD_F_MM_LO];

    always_comb begin
        fields = '0;
        fields.acc_b = word1[`IMD_F_ACC];
        fields.awb_en = !word1[`IMD_F_AWB_HI];
        fields.awb_inc = word1[`IMD_F_AWB_LO];
        fields.awb_reg = `IMD_W13;
        fields.xpf = pf_dec(word1[`IMD_F_XPF_HI:`IMD_F_XPF_LO],
                            `IMD_W8);
        fields.ypf = pf_dec(word1[`IMD_F_YPF_HI:`IMD_F_YPF_LO],
                            `IMD_W10);
        fields.x_dest = 4'(`IMD_W4 +
                           {2'h0, word1[`IMD_F_XD_HI:`IMD_F_XD_LO]});
        fields.bit_pos = word1[3:0];
        fields.default_work_register = `IMD_W0;
        fields.prog_lit = {word2[6:0], word1[15:0]};
        fields.lit_ok = !word1[0];
        if (cls == CL_SQR) begin
            fields.mul_ok = 1'b1;
            fields.mul_m = 4'(`IMD_W4 + {2'h0, mm[1:0]});
            fields.mul_n = fields.mul_m;
        end else begin
            fields.mul_ok = (mm < 3'h6);
            case (mm)
                3'h0: {fields.mul_m, fields.mul_n} = 8'h45;
                3'h1: {fields.mul_m, fields.mul_n} = 8'h46;
                3'h2: {fields.mul_m, fields.mul_n} = 8'h47;
                3'h3: {fields.mul_m, fields.mul_n} = 8'h56;
                3'h4: {fields.mul_m, fields.mul_n} = 8'h57;
                3'h5: {fields.mul_m, fields.mul_n} = 8'h67;
                default: {fields.mul_m, fields.mul_n} = 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- verilog/imd_decoder.sv
// instruction decode sequencer with cycle control and status flags
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "imd_cfg.svh"
// Notes on behaviour
// - 24-bit words, top 8 bits are opcode
// - second word of a pair has zero top byte
// - lone second word executes as a no-op
// - double-word instructions take two cycles
// - one cycle; taken test or jump adds no-op
// - branches, indirect, table, returns: two or three
// - taken skip: two or three cycles by length
// - double-word moves take two cycles
// - file instructions use register zero implicitly
// - accumulator field picks A or B
// - write-back goes to register 13 or post-increment
// - square uses one register from 4 to 7
// - multiply pair: two distinct registers 4 to 7
// - X prefetch through register 8 or 9
// - Y prefetch through register 10 or 11
// - X prefetch data lands in registers 4 to 7
// - program address literal has even bit zero
// - bit position field is 4 bits wide
// - five general flags held for instructions
// - four accumulator flags held for instructions
module imd_decoder
    import imd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        instr_valid,
    input  wire logic [23:0] instr_word,
    output logic             instr_ready,
    output logic             dword_follow,
    input  wire logic        cond_true,
    input  wire imd_flags_s  flag_we,
    input  wire imd_flags_s  flag_upd,
    output imd_flags_s       flags,
    output logic             exec_valid,
    output logic             exec_nop,
    output logic             exec_orphan,
    output imd_exec_s        exec_out
);
    function automatic imd_class_e classify(input logic [7:0] op);
        imd_class_e c;
        c = CL_PLAIN;
        if (op == `IMD_OP_NOP)
            c = CL_NOP;
        else if (op == `IMD_OP_GOTO || op == `IMD_OP_CALL ||
                 op == `IMD_OP_DO)
            c = CL_DWORD;
        else if (op == `IMD_OP_BRA)
            c = CL_BRA;
        else if (op[7:4] == `IMD_OP_CBR_GRP)
            c = CL_CBRA;
        else if (op == `IMD_OP_ICALL || op == `IMD_OP_IGOTO)
            c = CL_IND;
        else if (op == `IMD_OP_TBLRD || op == `IMD_OP_TBLWR)
            c = CL_TABLE;
        else if (op == `IMD_OP_RETURN || op == `IMD_OP_RETI)
            c = CL_RET;
        else if (op >= `IMD_OP_SKIP_LO && op <= `IMD_OP_SKIP_HI)
            c = CL_SKIP;
        else if (op == `IMD_OP_MOVD)
            c = CL_DMOVE;
        else if (op[7:4] == `IMD_OP_MAC_GRP)
            c = CL_MAC;
        else if (op == `IMD_OP_SQR)
            c = CL_SQR;
        return c;
    endfunction

    // extra no-op cycles after the issue cycle
    function automatic logic [1:0] extra_cyc(input imd_class_e c,
                                             input logic taken);
        logic [1:0] e;
        e = 2'h0;
        case (c)
            CL_BRA, CL_IND: e = `IMD_CYC_BRANCH - 2'h1;
            CL_TABLE:       e = `IMD_CYC_TABLE - 2'h1;
            CL_RET:         e = `IMD_CYC_RETURN - 2'h1;
            CL_DMOVE:       e = `IMD_CYC_DMOVE - 2'h1;
            CL_CBRA:        e = taken ? `IMD_CYC_TAKEN - 2'h1 : 2'h0;
            default:        e = 2'h0;
        endcase
        return e;
    endfunction

    imd_state_s  r;
    imd_state_s  n;
    imd_fields_s fld;
    imd_class_e  cls;
    logic [23:0] w1_sel;
    logic        acc;
    logic        req;
    logic [1:0]  extra;
    logic [2:0]  fault_set;

    assign w1_sel = (r.st == ST_SECOND) ? r.w1 : instr_word;
    assign cls = classify(w1_sel[`IMD_OPC_HI:`IMD_OPC_LO]);
    assign acc = instr_valid && instr_ready;
    assign req = avs_read || avs_write;
    assign extra = extra_cyc(cls, cond_true);

    imd_fields u_fields (
        .word1  (w1_sel),
        .word2  (instr_word),
        .cls    (cls),
        .fields (fld)
    );

    // stalls hold ready low so fetch cannot run ahead of the cycle count
    assign instr_ready = r.enable &&
                         (r.st != ST_STALL);
    assign dword_follow = (r.st == ST_SECOND) ||
                          (r.st == ST_FIRST && instr_valid &&
                           cls == CL_DWORD);
    assign avs_waitrequest = req && !r.ack;
    assign avs_readdata = r.rdata;
    assign flags = r.flags;
    assign exec_valid = r.ex_valid;
    assign exec_nop = r.ex_nop;
    assign exec_orphan = r.orphan;
    assign exec_out = r.ex;

    always_comb begin
        n = r;
        n.ex_valid = 1'b0;
        n.ex_nop = 1'b0;
        n.orphan = 1'b0;
        n.ack = req && !r.ack;
        fault_set = 3'h0;
        case (r.st)
            ST_FIRST: begin
                if (acc) begin
                    n.w1 = instr_word;
                    n.ex.word1 = instr_word;
                    n.ex.word2 = 24'h000000;
                    n.ex.cls = cls;
                    n.ex.f = fld;
                    if (cls == CL_DWORD) begin
                        n.st = ST_SECOND;
                    end else if (cls == CL_NOP) begin
                        // a stray second word lands here as a no-op
                        n.ex_nop = 1'b1;
                        n.orphan = 1'b1;
                    end else begin
                        n.ex_valid = 1'b1;
                        if ((cls == CL_MAC || cls == CL_SQR) &&
                            (!fld.mul_ok || (fld.awb_inc && !fld.awb_en)))
                            fault_set[2] = 1'b1;
                        if (cls == CL_SKIP && cond_true) begin
                            n.st = ST_SKIP1;
                        end else if (extra != 2'h0) begin
                            n.st = ST_STALL;
                            n.cnt = extra;
                        end
                    end
                end
            end
            ST_SECOND: begin
                if (acc) begin
                    n.ex_valid = 1'b1;
                    n.ex.word2 = instr_word;
                    n.ex.f = fld;
                    n.st = ST_FIRST;
                    if (instr_word[`IMD_OPC_HI:`IMD_OPC_LO] != 8'h00)
                        fault_set[0] = 1'b1;
                    if (r.w1[`IMD_OPC_HI:`IMD_OPC_LO] != `IMD_OP_DO &&
                        !fld.lit_ok)
                        fault_set[1] = 1'b1;
                end
            end
            ST_STALL: begin
                n.ex_nop = 1'b1;
                n.cnt = r.cnt - 2'h1;
                if (r.cnt == 2'h1)
                    n.st = ST_FIRST;
            end
            ST_SKIP1: begin
                if (acc) begin
                    n.ex_nop = 1'b1;
                    // a skipped pair costs one more cycle
                    n.st = (classify(instr_word[`IMD_OPC_HI:`IMD_OPC_LO])
                            == CL_DWORD) ? ST_SKIP2 : ST_FIRST;
                end
            end
            ST_SKIP2: begin
                if (acc) begin
                    n.ex_nop = 1'b1;
                    n.st = ST_FIRST;
                end
            end
            default: n.st = ST_FIRST;
        endcase
        if (r.ex_valid)
            n.icount = r.icount + 16'h0001;
        // bus write lands on the edge where waitrequest is seen low
        if (avs_write && r.ack) begin
            case (avs_address)
                `IMD_ADDR_STATUS:
                    n.flags = imd_flags_s'({avs_writedata[11:8],
                                            avs_writedata[4:0]});
                `IMD_ADDR_CTRL:
                    n.enable = avs_writedata[0];
                `IMD_ADDR_FAULT:
                    n.fault = n.fault & ~avs_writedata[2:0];
                default: n.enable = n.enable;
            endcase
        end
        // a fault raised in the clearing cycle must not be lost
        n.fault = n.fault | fault_set;
        // datapath updates beat a software write in the same cycle
        n.flags = (flag_we & flag_upd) | (~flag_we & n.flags);
        if (req && !r.ack) begin
            case (avs_address)
                `IMD_ADDR_STATUS:
                    n.rdata = {20'h00000, r.flags[8:5], 3'h0, r.flags[4:0]};
                `IMD_ADDR_CTRL:  n.rdata = {31'h00000000, r.enable};
                `IMD_ADDR_COUNT: n.rdata = {16'h0000, r.icount};
                `IMD_ADDR_FAULT: n.rdata = {29'h00000000, r.fault};
                default:         n.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
            r.st <= ST_FIRST;
            r.flags <= `IMD_RST_FLAGS;
            r.enable <= `IMD_RST_ENABLE;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    pair_start_a: assert property (
        (r.st == ST_FIRST && acc && cls == CL_DWORD) |=>
            r.st == ST_SECOND && !r.ex_valid)
        else $error("double word did not wait for its second word");
    pair_issue_a: assert property (
        (r.st == ST_SECOND && acc) |=> r.ex_valid && r.st == ST_FIRST)
        else $error("double word not issued on its second cycle");
    follow_flag_a: assert property (
        (r.st == ST_FIRST && acc && cls == CL_DWORD) |->
            dword_follow ##1 dword_follow)
        else $error("operand word not announced to fetch");
    hi_zero_a: assert property (
        (r.st == ST_SECOND && acc && instr_word[23:16] != 8'h00) |=>
            r.fault[0])
        else $error("nonzero second word top byte not reported");
    orphan_nop_a: assert property (
        (r.st == ST_FIRST && acc && instr_word[23:16] == 8'h00) |=>
            r.ex_nop && r.orphan && !r.ex_valid && r.st == ST_FIRST)
        else $error("lone second word did not act as a no-op");
    single_cyc_a: assert property (
        (r.st == ST_FIRST && acc && cls == CL_PLAIN) |=>
            r.ex_valid && instr_ready)
        else $error("plain instruction took more than one cycle");
    taken_cyc_a: assert property (
        (r.st == ST_FIRST && acc && cls == CL_CBRA && cond_true) |=>
            r.ex_valid && !instr_ready ##1 r.ex_nop ##1 !r.ex_nop)
        else $error("taken branch did not add one no-op cycle");
    ret_three_a: assert property (
        (r.st == ST_FIRST && acc && cls == CL_RET) |=>
            (r.st == ST_STALL)[*2] ##1 r.st == ST_FIRST)
        else $error("return did not take three cycles");
    flow_two_a: assert property (
        (r.st == ST_FIRST && acc &&
         (cls == CL_BRA || cls == CL_IND || cls == CL_TABLE)) |=>
            r.st == ST_STALL ##1 r.st == ST_FIRST)
        else $error("flow change did not take two cycles");
    skip_pair_a: assert property (
        (r.st == ST_SKIP1 && acc && instr_word[23:16] == `IMD_OP_GOTO) |=>
            r.ex_nop && r.st == ST_SKIP2)
        else $error("skipped pair did not cost a third cycle");
    dmove_two_a: assert property (
        (r.st == ST_FIRST && acc && cls == CL_DMOVE) |=>
            r.ex_valid ##1 r.ex_nop ##1 r.st == ST_FIRST)
        else $error("double move did not take two cycles");
    gen_flag_a: assert property (
        (flag_we[4:0] != 5'h00) |=>
            (r.flags[4:0] & $past(flag_we[4:0])) ==
            ($past(flag_upd[4:0]) & $past(flag_we[4:0])))
        else $error("general flag update lost");
    dsp_flag_a: assert property (
        (flag_we[8:5] != 4'h0) |=>
            (r.flags[8:5] & $past(flag_we[8:5])) ==
            ($past(flag_upd[8:5]) & $past(flag_we[8:5])))
        else $error("accumulator flag update lost");
    mul_pair_a: assert property (
        (cls == CL_MAC && fld.mul_ok) |->
            fld.mul_m != fld.mul_n && fld.mul_m >= 4'h4 && fld.mul_n <= 4'h7)
        else $error("multiply pair outside registers four to seven");
    sqr_same_a: assert property (
        (cls == CL_SQR) |-> fld.mul_m == fld.mul_n && fld.mul_m[3:2] == 2'h1)
        else $error("square operands differ");
    xpf_reg_a: assert property (
        fld.xpf.en |-> fld.xpf.rsel[3:1] == 3'h4 &&
            (!fld.xpf.idx || fld.xpf.rsel == 4'h9))
        else $error("X prefetch through wrong register");
    ypf_reg_a: assert property (
        fld.ypf.en |-> fld.ypf.rsel[3:1] == 3'h5 &&
            (!fld.ypf.idx || fld.ypf.rsel == 4'hB))
        else $error("Y prefetch through wrong register");
    lit_even_a: assert property (
        (r.st == ST_SECOND && acc && r.w1[23:16] == `IMD_OP_GOTO &&
         r.w1[0]) |=> r.fault[1])
        else $error("odd program address literal not reported");
endmodule
`default_nettype wire

//--- tb/imd_fetch_model.sv
// fetch unit model: queued words, held until the decoder takes them
`timescale 1ns/100ps
`default_nettype none
module imd_fetch_model (
    input  wire logic       mclk,
    input  wire logic       instr_ready,
    output var logic        instr_valid,
    output var logic [23:0] instr_word,
    output var logic        cond_true
);
    logic [24:0] q[$];
    initial begin
        instr_valid = 1'b0;
        instr_word = 24'hA5A5A5;
        cond_true = 1'b0;
    end
    task automatic push(input logic [23:0] w, input logic c);
        q.push_back({c, w});
    endtask
    always @(posedge mclk) begin
        if (instr_valid && instr_ready && q.size() > 0) begin
            void'(q.pop_front());
        end
        if (q.size() > 0) begin
            instr_valid <= 1'b1;
            instr_word <= q[0][23:0];
            cond_true <= q[0][24];
        end else begin
            instr_valid <= 1'b0;
            // idle lines wander so a stale word never looks valid
            instr_word <= ~instr_word;
            cond_true <= ~cond_true;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import imd_pkg::*;
;
    logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
    logic        instr_valid, instr_ready, dword_follow, cond_true;
    logic        exec_valid, exec_nop, exec_orphan;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [23:0] instr_word;
    imd_flags_s  flag_we, flag_upd, flags;
    imd_exec_s   exec_out;
    imd_fields_s fd;
    int          num_errors, comparisons, nv, nn, no, tot, cyc, i;
    logic [7:0]  ops[8] = '{8'h37, 8'h01, 8'h03, 8'hBA, 8'hBB, 8'hBE,
                            8'h06, 8'h07};
    logic [7:0]  pairs[6] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
    logic [3:0]  steps[6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hE, 4'hC};
    logic [4:0]  adr[5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};

    imd_decoder uut (
        .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .instr_valid, .instr_word,
        .instr_ready, .dword_follow, .cond_true, .flag_we, .flag_upd,
        .flags, .exec_valid, .exec_nop, .exec_orphan, .exec_out
    );
    imd_fetch_model fetch (
        .mclk, .instr_ready, .instr_valid, .instr_word, .cond_true
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // pulses are counted at the edge that ends them
    always @(posedge mclk) begin
        nv += int'(exec_valid);
        nn += int'(exec_nop);
        no += int'(exec_orphan);
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge mclk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        if (avs_waitrequest !== 1'b0)
            num_errors++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // waits until fetch is drained and the decoder sits idle
    task automatic run(input int v, input int n, input int o);
        int t;
        nv = 0;
        nn = 0;
        no = 0;
        t = 0;
        do begin
            @(negedge mclk);
            t++;
        end while (!(fetch.q.size() == 0 && instr_valid === 1'b0 &&
                     instr_ready === 1'b1 && exec_valid === 1'b0 &&
                     exec_nop === 1'b0) && t < 60);
        if (t >= 60)
            num_errors++;
        tot += nv;
        fd = exec_out.f;
        if (v >= 0) check(nv, v);
        if (n >= 0) check(nn, n);
        if (o >= 0) check(no, o);
    endtask

    task automatic fault(input logic [23:0] a, input logic [23:0] b,
                         input logic [31:0] e);
        fetch.push(a, 1'b0);
        fetch.push(b, 1'b0);
        run(-1, -1, -1);
        bus(1'b0, 5'h0C, 32'h0);
        check(rd, e);
        bus(1'b1, 5'h0C, e);
        bus(1'b0, 5'h0C, 32'h0);
        check(rd, 32'h0);
    endtask

    initial begin
        {rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        rst = 1'b1;
        flag_we = '0;
        flag_upd = '0;
        {num_errors, comparisons, nv, nn, no, tot, cyc} = '0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            bus(1'b0, adr[i], 32'h0);
            check(rd, (i == 1) ? 32'h1 : 32'h0);
        end
        // count is read-only and 0x10 is unmapped
        bus(1'b1, 5'h08, 32'hFFFF);
        bus(1'b1, 5'h10, 32'hFFFF);
        bus(1'b0, 5'h08, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 5'h10, 32'h0);
        check(rd, 32'h0);
        $display("register test done");
        fetch.push(24'h401234, 1'b0);
        run(1, 0, 0);
        fetch.push(24'h310000, 1'b0);
        run(1, 0, 0);
        fetch.push(24'h310000, 1'b1);
        run(1, 1, 0);
        for (i = 0; i < 8; i++) begin
            fetch.push({ops[i], 16'h0010}, 1'b0);
            run(1, (i < 6) ? 1 : 2, 0);
        end
        for (i = 0; i < 3; i++) begin
            fetch.push({8'h02 << i, 16'h0000}, 1'b0);
            run(0, 0, 0);
            check(dword_follow, 1'b1);
            fetch.push(24'h000002, 1'b0);
            run(1, 0, -1);
            check(exec_out.word2, 24'h000002);
            check(fd.prog_lit, 23'h020000);
        end
        fetch.push(24'h001234, 1'b0);
        run(0, 1, 1);
        for (i = 4; i < 8; i++) begin
            fetch.push({4'hA, i[3:0], 16'h0}, 1'b1);
            fetch.push(24'h401111, 1'b0);
            run(1, 1, -1);
        end
        fetch.push(24'hA50000, 1'b0);
        fetch.push(24'h401111, 1'b0);
        run(2, 0, 0);
        fetch.push(24'hA60000, 1'b1);
        fetch.push(24'h040000, 1'b0);
        fetch.push(24'h000004, 1'b0);
        run(1, 2, -1);
        bus(1'b0, 5'h08, 32'h0);
        check(rd, tot);
        $display("timing test done");
        fetch.push(24'hC0DF19, 1'b0);
        run(1, 0, 0);
        check({fd.acc_b, fd.awb_en, fd.awb_inc, fd.awb_reg}, 7'h7D);
        check({fd.xpf.en, fd.xpf.idx, fd.ypf.en, fd.ypf.idx}, 4'hE);
        check(fd.default_work_register, 4'h0);
        for (i = 0; i < 6; i++) begin
            fetch.push({8'hC0, i[0], i[2:0], i[3:0] + 4'h8, i[3:0] + 4'h1,
                        i[1:0], 2'b10}, 1'b0);
            run(1, 0, 0);
            check({fd.mul_m, fd.mul_n}, pairs[i]);
            check({fd.xpf.rsel, fd.xpf.step}, {4'h9, steps[i]});
            check({fd.ypf.rsel, fd.ypf.step}, {4'hA, steps[i]});
            check(fd.x_dest, 4'h4 + i[1:0]);
            check({fd.acc_b, fd.awb_en}, {i[0], 1'b0});
            check(fd.bit_pos, {i[1:0], 2'b10});
        end
        fetch.push(24'hF03000, 1'b0);
        run(1, 0, 0);
        check({fd.mul_m, fd.mul_n}, 8'h77);
        $display("field test done");
        fault(24'h040001, 24'h000000, 32'h2);
        fault(24'h040000, 24'h110000, 32'h1);
        fault(24'hC06000, 24'h000000, 32'h4);
        $display("fault test done");
        @(posedge mclk);
        flag_we <= '1;
        flag_upd <= '1;
        @(posedge mclk);
        flag_we <= '0;
        @(negedge mclk);
        check(flags, 9'h1FF);
        bus(1'b0, 5'h00, 32'h0);
        check(rd, 32'h0F1F);
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b0, 5'h00, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 5'h04, 32'h0);
        @(negedge mclk);
        check(instr_ready, 1'b0);
        bus(1'b1, 5'h04, 32'h1);
        @(negedge mclk);
        check(instr_ready, 1'b1);
        $display("flag and control test done");
        conclude();
    end
endmodule
`default_nettype wire
